// ===== rcl_checker.sv
// rcl_checker: timing relations between strap pins and latched outputs
// assumes: bound to reset_config_latch, everything on hclk
`timescale 1ns/100ps
`default_nettype none
module rcl_checker (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // pins seen by the block
    input wire logic reset_pin_n,
    input wire logic [1:0] range_mode_select_pins,
    input wire logic [2:0] channel_pair_select_pins,
    input wire logic conv_busy,
    // configuration outputs
    input wire logic config_valid,
    input wire logic software_mode,
    input wire logic internal_ref_en,
    input wire logic serial_if_en,
    input wire logic single_output_serial,
    input wire logic checksum_en,
    input wire logic burst_en,
    input wire logic sequencer_en,
    input wire rcl_pkg::rcl_os_type os_ratio,
    input wire logic [2:0] channel_pair,
    input wire rcl_pkg::rcl_range_type input_range,
    input wire logic sw_features_en,
    input wire logic conv_reset_pulse,
    input wire logic register_access_en
);
    import rcl_pkg::*;
    logic [5:0] low_cnt_q;
    wire logic hw_on = config_valid && !software_mode;
    // saturates so a long shutdown stays visible
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            low_cnt_q <= 6'h00;
        else
            low_cnt_q <= reset_pin_n ? 6'h00 : low_cnt_q + 6'(low_cnt_q != 6'h3F);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_hw_no_access: assert property (hw_on |-> !register_access_en)
        else $error("register access open in hardware mode");
    a_mode_held: assert property (config_valid && $past(config_valid) |->
        $stable({software_mode, internal_ref_en, serial_if_en, single_output_serial}))
        else $error("latched mode moved without full reset");
    a_hw_feat_held: assert property (hw_on && $past(hw_on) |->
        $stable({checksum_en, burst_en, sequencer_en, os_ratio}))
        else $error("hardware features moved after latch");
    a_par_restrict: assert property (hw_on && !serial_if_en |->
        !checksum_en && os_ratio == 3'b000 && !single_output_serial)
        else $error("parallel hardware shows serial-only features");
    a_sw_features: assert property (config_valid |-> sw_features_en == software_mode)
        else $error("software-only features mismatch mode");
    a_sync_delay: assert property ($rose(config_valid) |-> $past(reset_pin_n, 4))
        else $error("configuration latched before pin synchronised");
    a_full_drop: assert property (low_cnt_q == 6'd40 |-> !config_valid)
        else $error("long reset low did not drop configuration");
    a_partial_keep: assert property (config_valid && low_cnt_q < 6'd12 |=> config_valid)
        else $error("short reset low lost configuration");
    a_pulse_after: assert property ($rose(reset_pin_n) |-> ##[4:9] conv_reset_pulse)
        else $error("no conversion reset pulse after release");
    a_hw_range: assert property ((hw_on && reset_pin_n && range_mode_select_pins != 2'b00 &&
        $stable(range_mode_select_pins))[*6] |-> input_range == range_mode_select_pins)
        else $error("hardware range does not follow pins");
    a_busy_chan: assert property ((hw_on && reset_pin_n && conv_busy &&
        $stable(channel_pair_select_pins))[*6] |-> channel_pair == channel_pair_select_pins)
        else $error("channel pair not sampled while busy");
endmodule // rcl_checker
bind reset_config_latch rcl_checker i_rcl_checker (
    .hclk, .hresetn, .reset_pin_n, .range_mode_select_pins,
    .channel_pair_select_pins, .conv_busy, .config_valid, .software_mode,
    .internal_ref_en, .serial_if_en, .single_output_serial, .checksum_en,
    .burst_en, .sequencer_en, .os_ratio, .channel_pair, .input_range,
    .sw_features_en, .conv_reset_pulse, .register_access_en
);
`default_nettype wire

// ===== rcl_map.svh
// rcl_map.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the design files of the block
`ifndef RCL_MAP_SVH
`define RCL_MAP_SVH

// clock period and reset pulse classification
`define RCL_CLK_NS 40
`define RCL_FULL_RST_NS 1200
`define RCL_FULL_CYC ((`RCL_FULL_RST_NS + `RCL_CLK_NS - 1) / `RCL_CLK_NS)
`define RCL_CNT_W 5

// register byte offsets, config reset value and write mask
`define RCL_ADDR_STATUS 12'h000
`define RCL_ADDR_CONFIG 12'h004
`define RCL_CONFIG_RST 32'h0000_0000
`define RCL_CONFIG_MASK 32'h0000_07FF

// config register fields
`define RCL_CF_OS 2:0
`define RCL_CF_CHK 3
`define RCL_CF_BURST 4
`define RCL_CF_SEQ 5
`define RCL_CF_CHAN 8:6
`define RCL_CF_RANGE 10:9

// sync chain
`define RCL_SYNC_W 15
`define RCL_SYNC_RST 15'h0000

`endif

// ===== rcl_pin_sync.sv
// rcl_pin_sync: three-stage synchroniser for asynchronous pins
// assumes: output only moves when stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module rcl_pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // pins in, clean levels out
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);
    genvar i;

    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;

            // stage one feeds stage two and nothing else
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    s1_q <= RST_VAL[i];
                    s2_q <= RST_VAL[i];
                    s3_q <= RST_VAL[i];
                    pin_out[i] <= RST_VAL[i];
                end
                else
                begin
                    s1_q <= pin_in[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q)
                        pin_out[i] <= s3_q;
                end
            end
        end
    endgenerate
endmodule // rcl_pin_sync

`default_nettype wire

// ===== rcl_pkg.sv
// rcl_pkg: types shared by the reset configuration latch modules
// assumes: nothing beyond a SystemVerilog compiler
package rcl_pkg;

    typedef logic [2:0] rcl_os_type;
    typedef logic [1:0] rcl_range_type;

    // gray path: run -> low -> shutdown
    typedef enum logic [1:0] {
        RCL_ST_RUN = 2'b00,
        RCL_ST_LOW = 2'b01,
        RCL_ST_SHUT = 2'b11
    } rcl_state_type;

endpackage

// ===== rcl_reset_if.sv
// rcl_reset_if: reset pulse events from the timer to the latch core
// assumes: one clock domain, driven by rcl_reset_timer only
`timescale 1ns/100ps
`default_nettype none

interface rcl_reset_if;
    logic in_reset;
    logic shutdown;
    logic full_rel;
    logic part_rel;

    modport timer (
        output in_reset,
        output shutdown,
        output full_rel,
        output part_rel
    );

    modport core (
        input in_reset,
        input shutdown,
        input full_rel,
        input part_rel
    );
endinterface

`default_nettype wire

// ===== rcl_reset_timer.sv
// rcl_reset_timer: measures the low time of the reset pin
// assumes: pin_n is already synchronised to hclk
`timescale 1ns/100ps
`default_nettype none
`include "rcl_map.svh"

module rcl_reset_timer (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // synchronised reset pin level
    input wire logic pin_n,
    // classified events
    rcl_reset_if.timer evt
);
    import rcl_pkg::*;

    localparam logic [`RCL_CNT_W-1:0] FULL_LAST =
        `RCL_CNT_W'(`RCL_FULL_CYC - 1);

    rcl_state_type state_q;
    logic [`RCL_CNT_W-1:0] cnt_q;
    logic full_q;
    logic part_q;

    // power-up counts as a full reset, so the first release latches straps
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= RCL_ST_SHUT;
            cnt_q <= '0;
            full_q <= 1'b0;
            part_q <= 1'b0;
        end
        else
        begin
            full_q <= 1'b0;
            part_q <= 1'b0;
            case (state_q)
                RCL_ST_RUN:
                    if (!pin_n)
                    begin
                        state_q <= RCL_ST_LOW;
                        cnt_q <= `RCL_CNT_W'(1);
                    end
                RCL_ST_LOW:
                    if (pin_n)
                    begin
                        state_q <= RCL_ST_RUN;
                        part_q <= 1'b1;
                    end
                    else if (cnt_q >= FULL_LAST)
                        state_q <= RCL_ST_SHUT;
                    else
                        cnt_q <= cnt_q + `RCL_CNT_W'(1);
                RCL_ST_SHUT:
                    if (pin_n)
                    begin
                        state_q <= RCL_ST_RUN;
                        full_q <= 1'b1;
                    end
                default:
                    state_q <= RCL_ST_SHUT;
            endcase
        end
    end

    assign evt.in_reset = (state_q != RCL_ST_RUN);
    assign evt.shutdown = (state_q == RCL_ST_SHUT);
    assign evt.full_rel = full_q;
    assign evt.part_rel = part_q;
endmodule // rcl_reset_timer

`default_nettype wire

// ===== rcl_strap_host.sv
// rcl_strap_host: board straps, reset pin and busy source
// assumes: tasks are called by the bench, pins change after rising hclk
`timescale 1ns/100ps
`default_nettype none
module rcl_strap_host (
    // clock
    input wire logic hclk,
    // reset pin and straps
    output logic reset_pin_n,
    output logic [1:0] range_mode_select_pins,
    output logic reference_source_select,
    output logic interface_type_select,
    output logic single_output_serial_select,
    output logic checksum_enable_pin,
    output logic burst_enable_pin,
    output logic sequencer_enable_pin,
    output logic [2:0] oversampling_ratio_pins,
    output logic [2:0] channel_pair_select_pins,
    // conversion status
    output logic conv_busy
);
    logic [13:0] straps_q;
    assign {range_mode_select_pins, reference_source_select,
            interface_type_select, single_output_serial_select,
            checksum_enable_pin, burst_enable_pin, sequencer_enable_pin,
            oversampling_ratio_pins, channel_pair_select_pins} = straps_q;
    initial
    begin
        reset_pin_n = 1'b0;
        conv_busy = 1'b0;
        straps_q = 14'h0000;
    end
    // straps move with the falling pin and stay well past the rise
    task automatic pulse_reset(input logic [13:0] s, input int low_cycles);
        @(posedge hclk);
        straps_q <= s;
        reset_pin_n <= 1'b0;
        repeat (low_cycles) @(posedge hclk);
        reset_pin_n <= 1'b1;
        repeat (12) @(posedge hclk);
    endtask
    task automatic set_straps(input logic [13:0] s);
        @(posedge hclk);
        straps_q <= s;
    endtask
    // channel set before busy rises and held past its fall
    task automatic convert(input logic [2:0] ch);
        @(posedge hclk);
        straps_q[2:0] <= ch;
        @(posedge hclk);
        conv_busy <= 1'b1;
        repeat (10) @(posedge hclk);
        conv_busy <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask
endmodule // rcl_strap_host
`default_nettype wire

// ===== reset_config_latch.sv
// reset_config_latch: strap capture at reset release, with ahb-lite access
// assumes: ahb-lite master on hclk, strap pins and reset pin asynchronous,
// conv_busy comes from conversion logic on hclk
//
// Contract
// - mode is decided from range/mode pins at full reset release.
// - range/mode value 00 means software mode, else hardware with range.
// - in software mode later range/mode pin changes are ignored.
// - latched mode holds until the next full reset.
// - hardware mode refuses all config register accesses; status reads are still answered.
// - software mode takes interface, single-output and reference from pins, rest registers.
// - reference pin high enables internal reference, low selects external.
// - reference pin changes are ignored after latching.
// - interface pin low selects parallel, high selects serial.
// - serial interface also latches the single-output select pin.
// - interface and single-output pins are ignored after latching.
// - hardware mode latches checksum, burst, sequencer, oversampling pins.
// - reference, mode, interface, single-output pins latch in both modes.
// - hardware mode samples channel pair pins at any reset release.
// - in hardware mode channel pair pins are sampled while busy is high.
// - hardware range follows range pins at once; software ignores them.
// - feature availability depends on mode and interface type.
// - a low pulse of 1.2 us or more is a full reset.
// - a shorter low pulse is partial and keeps configuration.
`timescale 1ns/100ps
`default_nettype none
`include "rcl_map.svh"

module reset_config_latch (
    // clock and bus reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // device pins
    input wire logic reset_pin_n,
    input wire logic [1:0] range_mode_select_pins,
    input wire logic reference_source_select,
    input wire logic interface_type_select,
    input wire logic single_output_serial_select,
    input wire logic checksum_enable_pin,
    input wire logic burst_enable_pin,
    input wire logic sequencer_enable_pin,
    input wire logic [2:0] oversampling_ratio_pins,
    input wire logic [2:0] channel_pair_select_pins,
    // conversion logic
    input wire logic conv_busy,
    // configuration outputs
    output logic config_valid,
    output logic software_mode,
    output logic internal_ref_en,
    output logic serial_if_en,
    output logic single_output_serial,
    output logic checksum_en,
    output logic burst_en,
    output logic sequencer_en,
    output rcl_pkg::rcl_os_type os_ratio,
    output logic [2:0] channel_pair,
    output rcl_pkg::rcl_range_type input_range,
    output logic sw_features_en,
    output logic conv_reset_pulse,
    output logic register_access_en
);
    import rcl_pkg::*;

    // zero range code selects software mode; used at latch and range tracking
    function automatic logic is_sw_code(input rcl_range_type code);
        is_sw_code = (code == 2'b00);
    endfunction

    logic [`RCL_SYNC_W-1:0] raw_pins;
    logic [`RCL_SYNC_W-1:0] syn_pins;
    logic s_pin_n;
    rcl_range_type s_rng;
    logic s_ref;
    logic s_ser;
    logic s_one;
    logic s_chk;
    logic s_burst;
    logic s_seq;
    rcl_os_type s_os;
    logic [2:0] s_chan;

    rcl_reset_if rst_if ();

    assign raw_pins = {reset_pin_n, range_mode_select_pins,
                       reference_source_select, interface_type_select,
                       single_output_serial_select, checksum_enable_pin,
                       burst_enable_pin, sequencer_enable_pin,
                       oversampling_ratio_pins, channel_pair_select_pins};

    // all pins pass the three-stage chain before any capture
    rcl_pin_sync #(
        .WIDTH(`RCL_SYNC_W),
        .RST_VAL(`RCL_SYNC_RST)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in(raw_pins),
        .pin_out(syn_pins)
    );

    assign {s_pin_n, s_rng, s_ref, s_ser, s_one, s_chk, s_burst, s_seq,
            s_os, s_chan} = syn_pins;

    rcl_reset_timer u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_n(s_pin_n),
        .evt(rst_if.timer)
    );

    // latched straps
    logic valid_q;
    logic sw_q;
    logic ref_q;
    logic ser_q;
    logic one_q;
    logic hw_chk_q;
    logic hw_burst_q;
    logic hw_seq_q;
    rcl_os_type hw_os_q;
    rcl_range_type hw_rng_q;
    logic [2:0] hw_chan_q;
    logic [31:0] cfg_q;
    logic acc_en;

    // mode, reference and interface: only a full release updates them
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            valid_q <= 1'b0;
            sw_q <= 1'b0;
            ref_q <= 1'b0;
            ser_q <= 1'b0;
            one_q <= 1'b0;
        end
        else if (rst_if.full_rel)
        begin
            valid_q <= 1'b1;
            sw_q <= is_sw_code(s_rng);
            ref_q <= s_ref;
            ser_q <= s_ser;
            one_q <= s_ser & s_one;
        end
        else if (rst_if.shutdown)
            valid_q <= 1'b0;
    end

    // hardware-only straps; cleared when software mode is latched
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hw_chk_q <= 1'b0;
            hw_burst_q <= 1'b0;
            hw_seq_q <= 1'b0;
            hw_os_q <= '0;
        end
        else if (rst_if.full_rel)
        begin
            if (is_sw_code(s_rng))
            begin
                hw_chk_q <= 1'b0;
                hw_burst_q <= 1'b0;
                hw_seq_q <= 1'b0;
                hw_os_q <= '0;
            end
            else
            begin
                hw_chk_q <= s_chk;
                hw_burst_q <= s_burst;
                hw_seq_q <= s_seq;
                hw_os_q <= s_os;
            end
        end
    end

    // range pins are live in hardware mode; a zero code is never a range
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hw_rng_q <= 2'b01;
        else if (rst_if.full_rel && !is_sw_code(s_rng))
            hw_rng_q <= s_rng;
        else if (valid_q && !sw_q && !is_sw_code(s_rng))
            hw_rng_q <= s_rng;
    end

    // channel pair: in hardware mode taken at any release, then while busy is high
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hw_chan_q <= '0;
        else if (rst_if.full_rel && !is_sw_code(s_rng))
            hw_chan_q <= s_chan;
        else if (rst_if.part_rel && valid_q && !sw_q)
            hw_chan_q <= s_chan;
        else if (valid_q && !sw_q && !rst_if.in_reset && conv_busy)
            hw_chan_q <= s_chan;
    end

    // ahb-lite address phase capture
    logic ph_act_q;
    logic ph_wr_q;
    logic [11:0] ph_addr_q;
    logic [31:0] rd_d;
    logic [31:0] rd_q;
    logic [31:0] status;

    assign acc_en = valid_q & sw_q & ~rst_if.in_reset;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_act_q <= 1'b0;
            ph_wr_q <= 1'b0;
            ph_addr_q <= '0;
        end
        else if (hsel && hready && htrans[1])
        begin
            ph_act_q <= 1'b1;
            ph_wr_q <= hwrite & (hsize == 3'h2);
            ph_addr_q <= haddr[11:0];
        end
        else
            ph_act_q <= 1'b0;
    end

    assign status = {15'h0000, rst_if.in_reset, valid_q, input_range,
                     channel_pair, os_ratio, sequencer_en, burst_en,
                     checksum_en, single_output_serial, serial_if_en,
                     internal_ref_en, sw_q};

    // refused config reads return zero rather than stale values
    always_comb
    begin
        rd_d = 32'h0000_0000;
        case (haddr[11:0])
            `RCL_ADDR_STATUS: rd_d = status;
            `RCL_ADDR_CONFIG:
                if (acc_en)
                    rd_d = cfg_q;
            default: rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rd_q <= 32'h0000_0000;
        else if (hsel && hready && htrans[1] && !hwrite)
            rd_q <= rd_d;
    end

    // a full release clears the software settings before any new write
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cfg_q <= `RCL_CONFIG_RST;
        else if (rst_if.full_rel)
            cfg_q <= `RCL_CONFIG_RST;
        else if (ph_act_q && ph_wr_q && acc_en &&
                 ph_addr_q == `RCL_ADDR_CONFIG)
            cfg_q <= hwdata & `RCL_CONFIG_MASK;
    end

    assign hrdata = rd_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // effective configuration, registered for glitch-free outputs
    logic hw_par;
    logic out_chk_d;
    logic out_burst_d;
    logic out_seq_d;
    rcl_os_type out_os_d;
    logic [2:0] out_chan_d;
    rcl_range_type out_rng_d;

    assign hw_par = ~sw_q & ~ser_q;

    always_comb
    begin
        if (sw_q)
        begin
            out_chk_d = cfg_q[`RCL_CF_CHK];
            out_burst_d = cfg_q[`RCL_CF_BURST];
            out_seq_d = cfg_q[`RCL_CF_SEQ];
            out_os_d = cfg_q[`RCL_CF_OS];
            out_chan_d = cfg_q[`RCL_CF_CHAN];
            out_rng_d = cfg_q[`RCL_CF_RANGE];
        end
        else
        begin
            // parallel hardware mode has no oversampling and no checksum
            out_chk_d = hw_chk_q & ~hw_par;
            out_burst_d = hw_burst_q;
            out_seq_d = hw_seq_q;
            out_os_d = hw_par ? 3'h0 : hw_os_q;
            out_chan_d = hw_chan_q;
            out_rng_d = hw_rng_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            config_valid <= 1'b0;
            software_mode <= 1'b0;
            internal_ref_en <= 1'b0;
            serial_if_en <= 1'b0;
            single_output_serial <= 1'b0;
            checksum_en <= 1'b0;
            burst_en <= 1'b0;
            sequencer_en <= 1'b0;
            os_ratio <= '0;
            channel_pair <= '0;
            input_range <= '0;
            sw_features_en <= 1'b0;
            register_access_en <= 1'b0;
            conv_reset_pulse <= 1'b0;
        end
        else
        begin
            config_valid <= valid_q;
            software_mode <= sw_q;
            internal_ref_en <= ref_q;
            serial_if_en <= ser_q;
            single_output_serial <= one_q & ser_q;
            checksum_en <= valid_q & out_chk_d;
            burst_en <= valid_q & out_burst_d;
            sequencer_en <= valid_q & out_seq_d;
            os_ratio <= valid_q ? out_os_d : 3'h0;
            channel_pair <= out_chan_d;
            input_range <= out_rng_d;
            sw_features_en <= valid_q & sw_q;
            register_access_en <= acc_en;
            conv_reset_pulse <= rst_if.full_rel | rst_if.part_rel;
        end
    end
endmodule // reset_config_latch

`default_nettype wire

// ===== testbench.sv
// testbench: strap capture, register refusal and channel tracking
// assumes: rcl_strap_host drives the pins, this module is the ahb master
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import rcl_pkg::*;
    typedef struct packed {
        logic [13:0] straps;
        logic [13:0] flip;
        logic [14:0] outs;
        logic [31:0] cfg;
    } rcl_row_type;
    // straps {range,ref,serial,single,chk,burst,seq,os,chan}; flip = later noise
    localparam rcl_row_type ROWS [4] = '{
        '{14'h0FFF, 14'h3FF8, 15'h7800, 32'h0000_07FF},
        '{14'h0200, 14'h3FF8, 15'h4000, 32'h0000_07FF},
        '{14'h1D6B, 14'h0FF8, 15'h35AD, 32'h0000_0000},
        '{14'h339E, 14'h0FF8, 15'h021B, 32'h0000_0000}};
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, outs, rd;
    logic [1:0] htrans, range_mode_select_pins, input_range;
    logic [2:0] hsize, oversampling_ratio_pins, channel_pair_select_pins;
    logic [2:0] os_ratio, channel_pair;
    logic reset_pin_n, reference_source_select, interface_type_select;
    logic single_output_serial_select, checksum_enable_pin, burst_enable_pin;
    logic sequencer_enable_pin, conv_busy, config_valid, software_mode;
    logic internal_ref_en, serial_if_en, single_output_serial, checksum_en;
    logic burst_en, sequencer_en, sw_features_en, conv_reset_pulse;
    logic register_access_en;
    int n_mismatch, samples_checked, cyc, n_pulse, p0;
    assign outs = {17'h0_0000, software_mode, internal_ref_en, serial_if_en,
        single_output_serial, checksum_en, burst_en, sequencer_en, os_ratio,
        channel_pair, input_range};
    reset_config_latch i_reset_config_latch (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready(hreadyout),
        .hwdata, .hrdata, .hreadyout, .hresp, .reset_pin_n,
        .range_mode_select_pins, .reference_source_select,
        .interface_type_select, .single_output_serial_select,
        .checksum_enable_pin, .burst_enable_pin, .sequencer_enable_pin,
        .oversampling_ratio_pins, .channel_pair_select_pins, .conv_busy,
        .config_valid, .software_mode, .internal_ref_en, .serial_if_en,
        .single_output_serial, .checksum_en, .burst_en, .sequencer_en,
        .os_ratio, .channel_pair, .input_range, .sw_features_en,
        .conv_reset_pulse, .register_access_en);
    rcl_strap_host i_rcl_strap_host (
        .hclk, .reset_pin_n, .range_mode_select_pins, .reference_source_select,
        .interface_type_select, .single_output_serial_select,
        .checksum_enable_pin, .burst_enable_pin, .sequencer_enable_pin,
        .oversampling_ratio_pins, .channel_pair_select_pins, .conv_busy);
    always #20 hclk = ~hclk;
    task automatic summarize;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // the run is far shorter than this; a hang ends here
    always @(posedge hclk)
    begin
        cyc++;
        if (conv_reset_pulse === 1'b1)
            n_pulse++;
        if (cyc == 6000)
        begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // the one slave's hreadyout closes the loop as the bus's hready
    task automatic ahb(input logic wr, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'b010;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    initial
    begin
        {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            i_rcl_strap_host.pulse_reset(ROWS[i].straps, 45);
            chk(outs, 32'(ROWS[i].outs));
            i_rcl_strap_host.set_straps(ROWS[i].straps ^ ROWS[i].flip);
            repeat (10) @(posedge hclk);
            chk(outs, 32'(ROWS[i].outs));
            ahb(1'b1, 32'h0000_0004, 32'hFFFF_FFFF);
            ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
            chk(rd, ROWS[i].cfg);
            chk(32'(hresp), 32'h0000_0000);
            chk(32'({config_valid, register_access_en, sw_features_en}),
                32'({1'b1, {2{ROWS[i].outs[14]}}}));
            chk(outs, 32'(ROWS[i].outs) | ROWS[i].cfg);
            $display("test row %0d done", i);
        end
        p0 = n_pulse;
        i_rcl_strap_host.pulse_reset(14'h3C61, 8);
        chk(outs, 32'h0000_0207);
        chk(32'(n_pulse - p0), 32'h0000_0001);
        $display("test partial reset done");
        i_rcl_strap_host.convert(3'b010);
        chk(outs, 32'h0000_020B);
        i_rcl_strap_host.set_straps(14'h3C65);
        repeat (10) @(posedge hclk);
        chk(outs, 32'h0000_020B);
        $display("test busy channel done");
        i_rcl_strap_host.set_straps(14'h2C65);
        repeat (10) @(posedge hclk);
        chk(outs, 32'h0000_020A);
        ahb(1'b0, 32'h0000_0100, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("test range and unmapped done");
        summarize();
    end
endmodule // testbench
`default_nettype wire
